// ---- core/itc_inval_top.sv ----
// Translation-cache invalidation command registers behind an AXI4-Lite slave.
//
// Functional notes
// RULE1: Flag set in top byte starts invalidation.
// RULE2: Hardware clears flag when invalidation finishes.
// RULE3: Software leaves registers alone while flag set.
// RULE4: No request while context invalidation pending.
// RULE5: Flush write buffer first when configured.
// RULE6: Two-bit requested scope; 00 reserved.
// RULE7: Domain request carries domain id.
// RULE8: Page request loads address register first.
// RULE9: Hardware may widen scope to global.
// RULE10: Actual scope reported as flag clears.
// RULE11: Command register eight bytes above address.
// RULE12: Actual scope 00 means request ignored.
// RULE13: Other writes only store, never launch.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "itc_inval_regs.svh"
module itc_inval_top (
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    input  wire logic                      clkEn,
    input  wire logic [`ITC_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [`ITC_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic                           wbFlushReq,
    input  wire logic                      wbFlushAck,
    output logic                           invReq,
    input  wire logic                      invAck,
    output itc_pkg::itc_gran_t             invGran,
    output logic [`ITC_DID_W-1:0]          invDomain,
    output logic [63:0]                    invAddr
);
    import itc_pkg::*;

    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldW,
        input logic [31:0] newW,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = oldW;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = newW[8*i +: 8];
            end
        end
        return res;
    endfunction : mergeBytes

    ////////////////////////////////////////////////////////////////////////////
    // Write channel state.
    logic                   awPend_reg, awPend_next;
    logic [`ITC_ADDR_W-1:0] awAddr_reg, awAddr_next;
    logic                   wPend_reg, wPend_next;
    logic [31:0]            wData_reg, wData_next;
    logic [3:0]             wStrb_reg, wStrb_next;
    logic                   bValid_reg, bValid_next;
    logic [1:0]             bResp_reg, bResp_next;
    logic                   commit;
    logic [`ITC_ADDR_W-1:0] wrWord;
    logic                   wrMapped;

    assign s_axi_awready = !awPend_reg;
    assign s_axi_wready  = !wPend_reg;
    assign commit        = awPend_reg && wPend_reg && !bValid_reg;
    assign wrWord        = {awAddr_reg[`ITC_ADDR_W-1:2], 2'b00};

    always_comb begin
        wrMapped = (wrWord == `ITC_IVA_LO_OFF) || (wrWord == `ITC_IVA_HI_OFF) ||
                   (wrWord == `ITC_CMD_LO_OFF) || (wrWord == `ITC_CMD_HI_OFF) ||
                   (wrWord == `ITC_CFG_OFF)    || (wrWord == `ITC_STAT_OFF);
    end

    always_comb begin
        awPend_next = awPend_reg;
        awAddr_next = awAddr_reg;
        wPend_next  = wPend_reg;
        wData_next  = wData_reg;
        wStrb_next  = wStrb_reg;
        bValid_next = bValid_reg;
        bResp_next  = bResp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            awPend_next = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wPend_next = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        if (commit) begin
            awPend_next = 1'b0;
            wPend_next  = 1'b0;
            bValid_next = 1'b1;
            bResp_next  = wrMapped ? `ITC_RESP_OKAY : `ITC_RESP_SLVERR;
        end else if (bValid_reg && s_axi_bready) begin
            bValid_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            awPend_reg <= 1'b0;
            awAddr_reg <= '0;
            wPend_reg  <= 1'b0;
            wData_reg  <= `ITC_WORD_RST;
            wStrb_reg  <= 4'h0;
            bValid_reg <= 1'b0;
            bResp_reg  <= `ITC_RESP_OKAY;
        end else if (clkEn) begin
            awPend_reg <= awPend_next;
            awAddr_reg <= awAddr_next;
            wPend_reg  <= wPend_next;
            wData_reg  <= wData_next;
            wStrb_reg  <= wStrb_next;
            bValid_reg <= bValid_next;
            bResp_reg  <= bResp_next;
        end
    end

    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp  = bResp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Register file and command launch.
    logic [31:0]           ivaLo_reg, ivaLo_next;
    logic [31:0]           ivaHi_reg, ivaHi_next;
    logic [`ITC_DID_W-1:0] did_reg, did_next;
    itc_gran_t             reqGran_reg, reqGran_next;
    itc_gran_t             actGran_reg, actGran_next;
    logic                  flag_reg, flag_next;
    logic [1:0]            cfg_reg, cfg_next;
    logic                  start;
    logic [31:0]           mergedW;
    logic [31:0]           didMerged;
    logic                  engBusy;
    logic                  engDone;
    itc_gran_t             engDoneGran;

    assign mergedW   = mergeBytes(`ITC_WORD_RST, wData_reg, wStrb_reg);
    assign didMerged = mergeBytes({16'h0000, did_reg}, wData_reg, wStrb_reg);

    // RULE1: launch on flagged top byte
    assign start = commit && (wrWord == `ITC_CMD_HI_OFF) && !flag_reg &&
                   wStrb_reg[`ITC_MSB_LANE] && wData_reg[`ITC_FLAG_BIT];

    always_comb begin
        ivaLo_next   = ivaLo_reg;
        ivaHi_next   = ivaHi_reg;
        did_next     = did_reg;
        reqGran_next = reqGran_reg;
        actGran_next = actGran_reg;
        flag_next    = flag_reg;
        cfg_next     = cfg_reg;
        // RULE13: writes store fields only
        if (commit && !flag_reg) begin
            if (wrWord == `ITC_IVA_LO_OFF) begin
                ivaLo_next = mergeBytes(ivaLo_reg, wData_reg, wStrb_reg);
            end
            if (wrWord == `ITC_IVA_HI_OFF) begin
                ivaHi_next = mergeBytes(ivaHi_reg, wData_reg, wStrb_reg);
            end
            if (wrWord == `ITC_CMD_LO_OFF) begin
                did_next = didMerged[`ITC_DID_W-1:0];
            end
            // RULE6: capture requested scope
            if (wrWord == `ITC_CMD_HI_OFF && wStrb_reg[`ITC_MSB_LANE]) begin
                reqGran_next = itc_gran_t'(mergedW[`ITC_RGRAN_HI:`ITC_RGRAN_LO]);
            end
        end
        if (commit && wrWord == `ITC_CFG_OFF && wStrb_reg[0]) begin
            cfg_next = wData_reg[1:0];
        end
        if (start) begin
            flag_next = 1'b1;
        end else if (engDone) begin
            // RULE2: completion clears flag
            flag_next    = 1'b0;
            // RULE10: report performed scope
            actGran_next = engDoneGran;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ivaLo_reg   <= `ITC_WORD_RST;
            ivaHi_reg   <= `ITC_WORD_RST;
            did_reg     <= `ITC_DID_RST;
            reqGran_reg <= ITC_GRAN_RSVD;
            actGran_reg <= ITC_GRAN_RSVD;
            flag_reg    <= 1'b0;
            cfg_reg     <= `ITC_CFG_RST;
        end else if (clkEn) begin
            ivaLo_reg   <= ivaLo_next;
            ivaHi_reg   <= ivaHi_next;
            did_reg     <= did_next;
            reqGran_reg <= reqGran_next;
            actGran_reg <= actGran_next;
            flag_reg    <= flag_next;
            cfg_reg     <= cfg_next;
        end
    end

    // Domain and address are frozen while the flag is set, so the engine
    // can use them straight from the registers without a private copy.
    assign invDomain = did_reg;
    assign invAddr   = {ivaHi_reg, ivaLo_reg};

    itc_inval_engine u_engine (
        .core_clk      (core_clk),
        .nrst          (nrst),
        .clkEn         (clkEn),
        .start         (start),
        .reqGran       (itc_gran_t'(mergedW[`ITC_RGRAN_HI:`ITC_RGRAN_LO])),
        .flushRequired (cfg_reg[`ITC_CFG_FLUSH]),
        .forceGlobal   (cfg_reg[`ITC_CFG_GLOBAL]),
        .busy          (engBusy),
        .done          (engDone),
        .doneGran      (engDoneGran),
        .wbFlushReq    (wbFlushReq),
        .wbFlushAck    (wbFlushAck),
        .invReq        (invReq),
        .invAck        (invAck),
        .invGran       (invGran)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read channel.
    logic                   rValid_reg, rValid_next;
    logic [31:0]            rData_reg, rData_next;
    logic [1:0]             rResp_reg, rResp_next;
    logic [`ITC_ADDR_W-1:0] rdWord;
    logic [31:0]            rdMux;
    logic                   rdMapped;

    assign s_axi_arready = !rValid_reg;
    assign rdWord        = {s_axi_araddr[`ITC_ADDR_W-1:2], 2'b00};

    always_comb begin
        rdMux    = `ITC_WORD_RST;
        rdMapped = 1'b1;
        // RULE11: command sits above address
        case (rdWord)
            `ITC_IVA_LO_OFF: rdMux = ivaLo_reg;
            `ITC_IVA_HI_OFF: rdMux = ivaHi_reg;
            `ITC_CMD_LO_OFF: rdMux = {16'h0000, did_reg};
            `ITC_CMD_HI_OFF: begin
                rdMux[`ITC_FLAG_BIT]               = flag_reg;
                rdMux[`ITC_RGRAN_HI:`ITC_RGRAN_LO] = reqGran_reg;
                rdMux[`ITC_AGRAN_HI:`ITC_AGRAN_LO] = actGran_reg;
            end
            `ITC_CFG_OFF:    rdMux = {30'h00000000, cfg_reg};
            `ITC_STAT_OFF:   rdMux = {29'h00000000, invReq, wbFlushReq, engBusy};
            default:         rdMapped = 1'b0;
        endcase
    end

    always_comb begin
        rValid_next = rValid_reg;
        rData_next  = rData_reg;
        rResp_next  = rResp_reg;
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_next = 1'b1;
            rData_next  = rdMux;
            rResp_next  = rdMapped ? `ITC_RESP_OKAY : `ITC_RESP_SLVERR;
        end else if (rValid_reg && s_axi_rready) begin
            rValid_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rValid_reg <= 1'b0;
            rData_reg  <= `ITC_WORD_RST;
            rResp_reg  <= `ITC_RESP_OKAY;
        end else if (clkEn) begin
            rValid_reg <= rValid_next;
            rData_reg  <= rData_next;
            rResp_reg  <= rResp_next;
        end
    end

    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata  = rData_reg;
    assign s_axi_rresp  = rResp_reg;

    ////////////////////////////////////////////////////////////////////////////
    a_start_launch: assert property (@(posedge core_clk) disable iff (!nrst) // RULE1
        (clkEn && start) |=> flag_reg) else $error("flag not set on launch");
    a_store_only: assert property (@(posedge core_clk) disable iff (!nrst) // RULE13
        (clkEn && commit && !flag_reg &&
         !(wrWord == `ITC_CMD_HI_OFF && wStrb_reg[`ITC_MSB_LANE] && wData_reg[`ITC_FLAG_BIT]))
        |=> !flag_reg) else $error("launch without flagged top byte");
    a_flag_clear: assert property (@(posedge core_clk) disable iff (!nrst) // RULE2
        (clkEn && engDone) |=> !flag_reg) else $error("flag not cleared on completion");
    a_actual_report: assert property (@(posedge core_clk) disable iff (!nrst) // RULE10
        (clkEn && engDone) |=> actGran_reg == $past(engDoneGran)) else $error("wrong scope");
    a_busy_frozen: assert property (@(posedge core_clk) disable iff (!nrst) // RULE3
        (clkEn && flag_reg && !engDone) |=> $stable(invAddr) && $stable(invDomain))
        else $error("fields changed while flag set");
    c_global_done: cover property (@(posedge core_clk) disable iff (!nrst)
        start ##[1:30] (engDone && engDoneGran == ITC_GRAN_GLOBAL));
endmodule : itc_inval_top
`default_nettype wire

// ---- core/itc_inval_regs.svh ----
// Register offsets, field positions and reset values of the invalidation block.
`ifndef ITC_INVAL_REGS_SVH
`define ITC_INVAL_REGS_SVH

`define ITC_ADDR_W      8
`define ITC_WORD_STEP   8'h04
`define ITC_IVA_LO_OFF  8'h00
`define ITC_IVA_HI_OFF  (`ITC_IVA_LO_OFF + `ITC_WORD_STEP)
`define ITC_CMD_GAP     8'h08
`define ITC_CMD_LO_OFF  (`ITC_IVA_LO_OFF + `ITC_CMD_GAP)
`define ITC_CMD_HI_OFF  (`ITC_CMD_LO_OFF + `ITC_WORD_STEP)
`define ITC_CFG_OFF     8'h10
`define ITC_STAT_OFF    8'h14

`define ITC_FLAG_BIT    31
`define ITC_RGRAN_HI    29
`define ITC_RGRAN_LO    28
`define ITC_AGRAN_HI    26
`define ITC_AGRAN_LO    25
`define ITC_MSB_LANE    3
`define ITC_DID_W       16
`define ITC_CFG_FLUSH   0
`define ITC_CFG_GLOBAL  1

`define ITC_WORD_RST    32'h00000000
`define ITC_DID_RST     16'h0000
`define ITC_CFG_RST     2'h0
`define ITC_RESP_OKAY   2'h0
`define ITC_RESP_SLVERR 2'h2

`endif

// ---- core/itc_pkg.sv ----
// Types shared by the invalidation block.
package itc_pkg;

    typedef enum logic [1:0] {
        ITC_GRAN_RSVD   = 2'h0,
        ITC_GRAN_GLOBAL = 2'h1,
        ITC_GRAN_DOMAIN = 2'h2,
        ITC_GRAN_PAGE   = 2'h3
    } itc_gran_t;

    typedef enum logic [1:0] {
        ITC_IDLE,
        ITC_FLUSH,
        ITC_INVAL
    } itc_state_t;

endpackage : itc_pkg

// ---- core/itc_inval_engine.sv ----
// Sequencer that flushes the write buffer and then invalidates the cache.
`timescale 1ns/1ps
`default_nettype none
module itc_inval_engine (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic              clkEn,
    input  wire logic              start,
    input  wire itc_pkg::itc_gran_t reqGran,
    input  wire logic              flushRequired,
    input  wire logic              forceGlobal,
    output logic                   busy,
    output logic                   done,
    output itc_pkg::itc_gran_t     doneGran,
    output logic                   wbFlushReq,
    input  wire logic              wbFlushAck,
    output logic                   invReq,
    input  wire logic              invAck,
    output itc_pkg::itc_gran_t     invGran
);
    import itc_pkg::*;

    itc_state_t state_reg, state_next;
    itc_gran_t  gran_reg, gran_next;
    itc_gran_t  doneGran_reg, doneGran_next;
    logic       done_reg, done_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next    = state_reg;
        gran_next     = gran_reg;
        doneGran_next = doneGran_reg;
        done_next     = 1'b0;
        case (state_reg)
            ITC_IDLE: begin
                if (start) begin
                    // RULE12: reserved code ignored
                    if (reqGran == ITC_GRAN_RSVD) begin
                        done_next     = 1'b1;
                        doneGran_next = ITC_GRAN_RSVD;
                    end else begin
                        // RULE9: optional coarser scope
                        gran_next  = forceGlobal ? ITC_GRAN_GLOBAL : reqGran;
                        // RULE5: flush goes first
                        state_next = flushRequired ? ITC_FLUSH : ITC_INVAL;
                    end
                end
            end
            ITC_FLUSH: begin
                if (wbFlushAck) begin
                    state_next = ITC_INVAL;
                end
            end
            ITC_INVAL: begin
                if (invAck) begin
                    state_next    = ITC_IDLE;
                    done_next     = 1'b1;
                    doneGran_next = gran_reg;
                end
            end
            default: begin
                state_next = ITC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= ITC_IDLE;
            gran_reg     <= ITC_GRAN_RSVD;
            doneGran_reg <= ITC_GRAN_RSVD;
            done_reg     <= 1'b0;
        end else if (clkEn) begin
            state_reg    <= state_next;
            gran_reg     <= gran_next;
            doneGran_reg <= doneGran_next;
            done_reg     <= done_next;
        end
    end

    assign busy       = (state_reg != ITC_IDLE);
    assign done       = done_reg;
    assign doneGran   = doneGran_reg;
    assign wbFlushReq = (state_reg == ITC_FLUSH);
    assign invReq     = (state_reg == ITC_INVAL);
    assign invGran    = gran_reg;

    ////////////////////////////////////////////////////////////////////////////
    a_flush_first: assert property (@(posedge core_clk) disable iff (!nrst) // RULE5
        (clkEn && !busy && start && flushRequired && reqGran != ITC_GRAN_RSVD)
        |=> wbFlushReq && !invReq) else $error("flush did not precede invalidation");
    a_inval_after_flush: assert property (@(posedge core_clk) disable iff (!nrst) // RULE5
        (clkEn && wbFlushReq && wbFlushAck) |=> invReq) else $error("no invalidation after flush");
    a_rsvd_ignored: assert property (@(posedge core_clk) disable iff (!nrst) // RULE12
        (clkEn && !busy && start && reqGran == ITC_GRAN_RSVD)
        |=> done && doneGran == ITC_GRAN_RSVD && !invReq) else $error("reserved request acted on");
    a_coarse_global: assert property (@(posedge core_clk) disable iff (!nrst) // RULE9
        (clkEn && !busy && start && forceGlobal && reqGran != ITC_GRAN_RSVD)
        |=> invGran == ITC_GRAN_GLOBAL) else $error("forced global scope not used");
    a_req_held: assert property (@(posedge core_clk) disable iff (!nrst) // RULE6
        (clkEn && invReq && !invAck) |=> invReq && $stable(invGran)) else $error("request dropped");
    c_flush_path: cover property (@(posedge core_clk) disable iff (!nrst)
        wbFlushReq ##[1:20] (invReq && invAck));
    c_rsvd_path: cover property (@(posedge core_clk) disable iff (!nrst)
        done && doneGran == ITC_GRAN_RSVD);
endmodule : itc_inval_engine
`default_nettype wire

// ---- bench/tb_itc_inval_top.sv ----
// Self-checking bench for the translation-cache invalidation registers.
`timescale 1ns/1ps
`default_nettype none
`include "itc_inval_regs.svh"
module tb_itc_inval_top;
    import itc_pkg::*;
    logic        core_clk = 1'b0;
    logic        nrst     = 1'b0;
    logic [7:0]  awaddr   = 8'h00;
    logic [7:0]  araddr   = 8'h00;
    logic [31:0] wdata    = 32'h0;
    logic [3:0]  wstrb    = 4'h0;
    logic        awvalid  = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        wbFlushAck = 1'b0, invAck = 1'b0, sawFlush = 1'b0, clkEn = 1'b1;
    logic        awready, wready, bvalid, arready, rvalid, wbFlushReq, invReq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    itc_gran_t   invGran;
    logic [15:0] invDomain;
    logic [63:0] invAddr;
    logic [31:0] seed = 32'hDB6DF00F;
    int          failures = 0, n_tests = 0, cycles = 0, ackDly = 2, fc = 0, ic = 0;
    logic [34:0] expR[$];
    logic [1:0]  expB[$];
    logic [82:0] expI[$];

    always #12.5 core_clk = ~core_clk;

    itc_inval_top u_itc_inval_top (
        .core_clk(core_clk), .nrst(nrst), .clkEn(clkEn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .wbFlushReq(wbFlushReq), .wbFlushAck(wbFlushAck), .invReq(invReq), .invAck(invAck),
        .invGran(invGran), .invDomain(invDomain), .invAddr(invAddr)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic summarize();
        $display("Checks made %0d, failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] s);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        expB.push_back(er);
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e,
                      input logic [1:0] er, output logic [31:0] got);
        expR.push_back({c, er, e});
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        got = rdata;
        rready <= 1'b0;
        @(posedge core_clk);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        logic [34:0] e;
        cycles++;
        if (rvalid && rready) begin
            e = expR.pop_front();
            if (e[34]) cmp("read", {30'h0, e[33:0]}, {30'h0, rresp, rdata});
        end
        if (bvalid && bready) cmp("bresp", {62'h0, expB.pop_front()}, {62'h0, bresp});
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    // Acks come after a variable stall and stand until the request drops.
    always @(posedge core_clk) begin
        logic [82:0] g;
        logic        fa;
        logic        ia;
        fa = 1'b0;
        ia = 1'b0;
        if (wbFlushReq) begin
            sawFlush = 1'b1;
            if (fc >= ackDly) begin
                fa = 1'b1;
            end else begin
                fc++;
            end
        end else begin
            fc = 0;
        end
        if (invReq) begin
            if (ic == 0 && expI.size() == 0) cmp("unexpectedInv", 64'h0, 64'h1);
            else if (ic == 0) begin
                g = expI.pop_front();
                cmp("flushFirst", {63'h0, g[82]}, {63'h0, sawFlush});
                cmp("invGran", {62'h0, g[81:80]}, {62'h0, invGran});
                cmp("invDomain", {48'h0, g[79:64]}, {48'h0, invDomain});
                cmp("invAddr", g[63:0], invAddr);
                sawFlush = 1'b0;
            end
            if (ic >= ackDly) begin
                ia = 1'b1;
            end else begin
                ic++;
            end
        end else begin
            ic = 0;
        end
        wbFlushAck <= fa;
        invAck     <= ia;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic launch(input logic [1:0] gr, input logic [1:0] cfg, input logic intr);
        logic [15:0] domain_id_field;
        logic [63:0] ad;
        logic [1:0]  act;
        logic [31:0] got;
        int          k;
        got = rnd();
        domain_id_field = got[15:0];
        ad  = {rnd(), rnd()};
        act = (gr == 2'h0) ? 2'h0 : (cfg[1] ? 2'h1 : gr);
        ackDly = intr ? 20 : 2 + int'(rnd() % 3);
        wr(`ITC_CFG_OFF, {30'h0, cfg}, 4'hF, `ITC_RESP_OKAY);
        wr(`ITC_IVA_LO_OFF, ad[31:0], 4'hF, `ITC_RESP_OKAY);
        wr(`ITC_IVA_HI_OFF, ad[63:32], 4'hF, `ITC_RESP_OKAY);
        wr(`ITC_CMD_LO_OFF, {16'h0, domain_id_field}, 4'hF, `ITC_RESP_OKAY);
        if (gr != 2'h0) expI.push_back({cfg[0], act, domain_id_field, ad});
        // no context-cache request is ever outstanding in this bench.
        wr(`ITC_CMD_HI_OFF, {2'b10, gr, 28'h0}, 4'h8, `ITC_RESP_OKAY);
        if (intr) begin
            // Writes while busy must change nothing and start nothing.
            wr(`ITC_IVA_LO_OFF, ~ad[31:0], 4'hF, `ITC_RESP_OKAY);
            wr(`ITC_CMD_LO_OFF, {16'h0, ~domain_id_field}, 4'hF, `ITC_RESP_OKAY);
            wr(`ITC_CMD_HI_OFF, {2'b10, gr, 28'h0}, 4'h8, `ITC_RESP_OKAY);
            // The ack arrives while frozen, so the request must still stand.
            clkEn <= 1'b0;
            repeat (20) @(posedge core_clk);
            cmp("frozenReq", 64'h1, {63'h0, invReq});
            clkEn <= 1'b1;
        end
        k = 0;
        do begin
            rd(`ITC_CMD_HI_OFF, 1'b0, 32'h0, `ITC_RESP_OKAY, got);
            if (k == 0 && gr != 2'h0) cmp("flagSet", 64'h1, {63'h0, got[31]});
            k++;
        end while (got[31] && k < 200);
        rd(`ITC_CMD_HI_OFF, 1'b1, {2'b00, gr, 1'b0, act, 25'h0}, `ITC_RESP_OKAY, got);
        rd(`ITC_IVA_LO_OFF, 1'b1, ad[31:0], `ITC_RESP_OKAY, got);
        rd(`ITC_CMD_LO_OFF, 1'b1, {16'h0, domain_id_field}, `ITC_RESP_OKAY, got);
    endtask : launch

    initial begin
        logic [31:0] got;
        int          a;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        for (a = 0; a <= 8'h18; a += 4) begin
            rd(a[7:0], 1'b1, 32'h0, (a == 8'h18) ? `ITC_RESP_SLVERR : `ITC_RESP_OKAY, got);
        end
        wr(8'h1C, rnd(), 4'hF, `ITC_RESP_SLVERR);
        wr(`ITC_CMD_HI_OFF, 32'h90000000, 4'h7, `ITC_RESP_OKAY);
        wr(`ITC_CMD_HI_OFF, 32'h30000000, 4'hF, `ITC_RESP_OKAY);
        rd(`ITC_CMD_HI_OFF, 1'b1, 32'h30000000, `ITC_RESP_OKAY, got);
        // Every scope, with and without flush and forced global scope.
        for (int c = 0; c < 4; c++) begin
            for (int g = 0; g < 4; g++) begin
                launch(g[1:0], c[1:0], c == 0 && g == 3);
            end
        end
        repeat (4) @(posedge core_clk);
        cmp("pendingInv", 64'h0, 64'(expI.size()));
        summarize();
    end
endmodule : tb_itc_inval_top
`default_nettype wire
